// File: rtl/sff_framer.sv
// Frame builder and header scanner for an FSK radio link.
// Assumes the MAC and the modulator run on CLK_IN; no pin syncs.
// Behaviour
// (R1) Only ordinary data frames are built; no mode-switch frame exists here.
// (R2) Each frame opens with eight preamble units.
// (R3) Only the delimiter of selection zero is sent and searched for.
// (R4) The mode-switch bit of every sent header is zero.
// (R5) The FCS-type bit is sent as zero and ignored when received.
// (R6) The whitening bit of every sent header is one and the payload is whitened.
// (R7) The 863 to 870 MHz band is supported; others are optional.
// (R8) Operating mode one is always available; mode two is optional.
// (R9) Software picks the mode by a register; the block never changes it.
// (R10) FEC on or off comes from a register; when on, the NRNSC code is used.
// (R11) Code-symbol interleaving is applied with the NRNSC code.
// (R12) Mode and FEC settings are taken only while no frame is in progress.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
module sff_framer
  import sff_pkg::*;
#(
  parameter bit MODE2_OK = 1'b1
) (
  // Clock and reset
  input  wire logic             CLK_IN,
  input  wire logic             RESET_IN,
  // APB slave
  input  wire logic             PSEL_IN,
  input  wire logic             PENABLE_IN,
  input  wire logic             PWRITE_IN,
  input  wire logic [11:0]      PADDR_IN,
  input  wire logic [31:0]      PWDATA_IN,
  output logic      [31:0]      PRDATA_OUT,
  output logic                  PREADY_OUT,
  output logic                  PSLVERR_OUT,
  // MAC transmit side
  input  wire logic             TX_START_IN,
  input  wire logic [LEN_W-1:0] TX_LEN_IN,
  input  wire logic [7:0]       TX_DATA_IN,
  input  wire logic             TX_VALID_IN,
  output logic                  TX_READY_OUT,
  output logic                  TX_DONE_OUT,
  // Modulator side
  output logic                  TX_BIT_OUT,
  output logic                  TX_BIT_VALID_OUT,
  input  wire logic             TX_BIT_READY_IN,
  output logic                  TX_MODE_OUT,
  output logic                  TX_FEC_OUT,
  // Demodulator and MAC receive side
  input  wire logic             RX_BIT_IN,
  input  wire logic             RX_BIT_VALID_IN,
  output logic                  RX_HDR_STB_OUT,
  output logic      [LEN_W-1:0] RX_LEN_OUT,
  output logic                  RX_DW_OUT
);
  typedef struct packed {
    sff_phase_t       ph;
    logic [3:0]       unit;
    logic [LEN_W-1:0] plen;
    logic [LEN_W-1:0] send;
    logic [LEN_W-1:0] fetch;
    logic [15:0]      sh;
    logic [4:0]       cnt;
    logic             valid;
    logic [8:0]       pn;
    logic [2:0]       enc;
    logic [7:0]       pbyte;
    logic             phave;
    logic             rdy;
    logic             done;
    logic             mode;
    logic             fec;
    logic             c_mode;
    logic             c_fec;
    logic [15:0]      txcnt;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic [15:0]      rsh;
    logic             rhdr;
    logic             rseen;
    logic [4:0]       rbits;
    logic [LEN_W-1:0] rlen;
    logic             rdw;
    logic             rstb;
  } sff_state_t;

  localparam sff_state_t ST_RST = '{
    ph: PH_IDLE,
    c_mode: CTRL_MODE_RST,
    c_fec: CTRL_FEC_RST,
    pn: PN9_SEED,
    default: '0
  };

  sff_state_t s_q;
  sff_state_t s_d;

  logic [15:0] phr;
  logic [7:0]  unit_byte;
  logic [7:0]  wh_byte;
  logic [8:0]  pn_nxt;
  logic [15:0] coded;
  logic [2:0]  enc_nxt;
  logic [15:0] unit_word;
  logic [4:0]  unit_bits;

  // Header fields fixed: no mode switch, FCS type zero, whitening on
  assign phr = {PHR_MS_VAL, 2'b00, PHR_FCS_VAL, PHR_DW_VAL, s_q.plen}; // (R4) (R5) (R6)

  // Byte feeding the coder for the unit about to load
  always_comb begin
    case (s_q.ph)
      PH_PHR: begin
        unit_byte = (s_q.unit == 4'h0) ? phr[15:8] : phr[7:0];
      end
      PH_PAY: begin
        unit_byte = wh_byte;
      end
      default: begin
        // Tail and idle feed zeros, which also flush the coder
        unit_byte = 8'h00;
      end
    endcase
  end

  sff_whiten u_whiten (
    .data_in  (s_q.pbyte),
    .pn_in    (s_q.pn),
    .data_out (wh_byte),
    .pn_out   (pn_nxt)
  );

  sff_fec u_fec (
    .data_in  (unit_byte),
    .mem_in   (s_q.enc),
    .code_out (coded),
    .mem_out  (enc_nxt)
  );

  // Coded bytes go out as sixteen interleaved bits
  assign unit_word = s_q.fec ? coded : {unit_byte, 8'h00}; // (R10) (R11)
  assign unit_bits = s_q.fec ? BITS_FEC : BITS_UNC;

  always_comb begin
    logic [15:0] rnew;
    logic        busy;
    logic        apb_setup;
    logic        apb_wr_ctrl;
    logic        tx_go;
    logic        tx_take;
    logic        mac_take;
    logic        rx_sfd;
    logic        rx_last;
    rnew = {s_q.rsh[14:0], RX_BIT_IN};
    busy = (s_q.ph != PH_IDLE);
    // Setup only; the access phase just completes what setup prepared
    apb_setup = PSEL_IN && !PENABLE_IN;
    apb_wr_ctrl = PSEL_IN && PENABLE_IN && s_q.pready && PWRITE_IN && (PADDR_IN == REG_CTRL);
    // A start while busy is dropped, never queued
    tx_go = !busy && TX_START_IN;
    tx_take = s_q.valid && TX_BIT_READY_IN;
    mac_take = s_q.rdy && TX_VALID_IN;
    // One delimiter only; the coded one when FEC is selected
    rx_sfd = (rnew == (s_q.c_fec ? SFD0_FEC : SFD0_UNC)); // (R3)
    rx_last = (s_q.rbits == RX_PHR_LAST);
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rstb = 1'b0;

    // APB: answer prepared in setup, so access completes at once
    s_d.pready = apb_setup;
    if (apb_setup) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      case (PADDR_IN)
        REG_CTRL: begin
          s_d.prdata[CTRL_MODE_BIT] = s_q.c_mode;
          s_d.prdata[CTRL_FEC_BIT] = s_q.c_fec;
        end
        REG_STATUS: begin
          s_d.prdata[ST_BUSY_BIT] = busy;
          s_d.prdata[ST_MODE_BIT] = s_q.mode;
          s_d.prdata[ST_FEC_BIT] = s_q.fec;
          s_d.prdata[ST_RXH_BIT] = s_q.rseen;
          s_d.prdata[ST_BAND_LSB +: 2] = BAND_863_870; // (R7)
        end
        REG_TXCNT: begin
          s_d.prdata[15:0] = s_q.txcnt;
        end
        REG_RXPHR: begin
          s_d.prdata[LEN_W-1:0] = s_q.rlen;
          s_d.prdata[RXPHR_DW_BIT] = s_q.rdw;
        end
        default: begin
          // Unmapped: error flagged, any write dropped
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (apb_wr_ctrl) begin
      // Mode two stays unselectable when not built in
      s_d.c_mode = PWDATA_IN[CTRL_MODE_BIT] & MODE2_OK; // (R8) (R9)
      s_d.c_fec = PWDATA_IN[CTRL_FEC_BIT]; // (R10)
    end

    // Frame start: settings frozen for the whole frame
    if (tx_go) begin
      s_d.ph = PH_PRE;
      s_d.unit = 4'h0;
      s_d.plen = TX_LEN_IN;
      s_d.send = TX_LEN_IN;
      s_d.fetch = TX_LEN_IN;
      s_d.mode = s_q.c_mode; // (R12)
      s_d.fec = s_q.c_fec; // (R12)
      s_d.pn = PN9_SEED;
      s_d.enc = 3'h0;
      s_d.phave = 1'b0;
    end

    // Modulator takes one bit, msb first
    if (tx_take) begin
      s_d.sh = {s_q.sh[14:0], 1'b0};
      s_d.cnt = s_q.cnt - 5'h01;
    end

    // Payload byte prefetch from the MAC
    if (mac_take) begin
      s_d.pbyte = TX_DATA_IN;
      s_d.phave = 1'b1;
      s_d.fetch = s_q.fetch - 1'b1;
    end

    // Next unit loads one cycle after the last bit left
    if (s_q.cnt == 5'h00) begin
      case (s_q.ph)
        PH_IDLE: begin
          // Nothing to load; must not undo a start taken in this cycle
        end
        PH_PRE: begin
          s_d.sh = {PRE_BYTE, 8'h00};
          s_d.cnt = BITS_UNC;
          s_d.unit = s_q.unit + 4'h1;
          if (s_q.unit == PRE_UNITS - 4'h1) begin // (R2)
            s_d.ph = PH_SFD;
          end
        end
        PH_SFD: begin
          // Only selection zero exists; no mode-switch frame path
          s_d.sh = s_q.fec ? SFD0_FEC : SFD0_UNC; // (R3) (R1)
          s_d.cnt = BITS_SFD;
          s_d.unit = 4'h0;
          s_d.ph = PH_PHR;
        end
        PH_PHR: begin
          s_d.sh = unit_word;
          s_d.cnt = unit_bits;
          s_d.enc = enc_nxt;
          s_d.unit = s_q.unit + 4'h1;
          if (s_q.unit == 4'h1) begin
            if (s_q.send != '0) begin
              s_d.ph = PH_PAY;
            end else begin
              s_d.ph = s_q.fec ? PH_TAIL : PH_END;
            end
          end
        end
        PH_PAY: begin
          // A late MAC byte stalls the bit stream, not the frame
          if (s_q.phave) begin
            s_d.sh = unit_word;
            s_d.cnt = unit_bits;
            s_d.enc = enc_nxt;
            s_d.pn = pn_nxt; // (R6)
            s_d.phave = 1'b0;
            s_d.send = s_q.send - 1'b1;
            if (s_q.send == 1) begin
              s_d.ph = s_q.fec ? PH_TAIL : PH_END;
            end
          end
        end
        PH_TAIL: begin
          // Zero byte flushes the encoder memory
          s_d.sh = unit_word;
          s_d.cnt = unit_bits;
          s_d.enc = enc_nxt;
          s_d.ph = PH_END;
        end
        PH_END: begin
          // Idle from the next cycle, so a start can follow the done pulse
          s_d.ph = PH_IDLE;
          s_d.done = 1'b1;
          s_d.txcnt = s_q.txcnt + 16'h0001;
        end
        default: begin
          s_d.ph = PH_IDLE;
        end
      endcase
    end
    // One unit shifts at a time, so one counter serves every phase
    s_d.valid = (s_d.cnt != 5'h00);
    s_d.rdy = (s_d.ph != PH_IDLE) && (s_d.ph != PH_END) && !s_d.phave && (s_d.fetch != '0);

    // Receive: hunt for the one delimiter, then read the header if FEC is off
    if (RX_BIT_VALID_IN) begin
      s_d.rsh = rnew;
      if (!s_q.rhdr) begin
        if (rx_sfd) begin // (R3)
          // Coded headers are left to the decoder downstream
          s_d.rhdr = ~s_q.c_fec;
          s_d.rbits = 5'h00;
        end
      end else begin
        s_d.rbits = s_q.rbits + 5'h01;
        if (rx_last) begin
          // FCS-type bit deliberately not looked at
          s_d.rhdr = 1'b0;
          s_d.rlen = rnew[LEN_W-1:0]; // (R5)
          s_d.rdw = rnew[PHR_DW_BIT];
          s_d.rstb = 1'b1;
          s_d.rseen = 1'b1;
        end
      end
    end
  end

  // Sync reset; every register clocks on every edge
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs are state bits, no logic after the flops
  assign PRDATA_OUT = s_q.prdata;
  assign PREADY_OUT = s_q.pready;
  assign PSLVERR_OUT = s_q.pslverr;
  assign TX_READY_OUT = s_q.rdy;
  assign TX_DONE_OUT = s_q.done;
  assign TX_BIT_OUT = s_q.sh[15];
  assign TX_BIT_VALID_OUT = s_q.valid;
  assign TX_MODE_OUT = s_q.mode;
  assign TX_FEC_OUT = s_q.fec;
  assign RX_HDR_STB_OUT = s_q.rstb;
  assign RX_LEN_OUT = s_q.rlen;
  assign RX_DW_OUT = s_q.rdw;
endmodule

// File: rtl/sff_pkg.sv
// Constants for the frame builder: register map, header layout, codes.
// Shared by the framer top and its coding helpers.
package sff_pkg;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TXCNT  = 12'h008;
  localparam logic [11:0] REG_RXPHR  = 12'h00C;
  // Control fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_FEC_BIT  = 1;
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam logic CTRL_FEC_RST  = 1'b0;
  // Status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_MODE_BIT = 1;
  localparam int ST_FEC_BIT  = 2;
  localparam int ST_RXH_BIT  = 3;
  localparam int ST_BAND_LSB = 4;
  localparam logic [1:0] BAND_863_870 = 2'h0;
  localparam int RXPHR_DW_BIT = 16;
  // Sync header
  localparam logic [3:0]  PRE_UNITS = 4'h8;
  localparam logic [7:0]  PRE_BYTE  = 8'h55;
  localparam logic [15:0] SFD0_UNC  = 16'h904E;
  localparam logic [15:0] SFD0_FEC  = 16'h6F4E;
  // PHY header layout
  localparam int PHR_MS_BIT  = 15;
  localparam int PHR_FCS_BIT = 12;
  localparam int PHR_DW_BIT  = 11;
  localparam int LEN_W = 11;
  localparam logic PHR_MS_VAL  = 1'b0;
  localparam logic PHR_FCS_VAL = 1'b0;
  localparam logic PHR_DW_VAL  = 1'b1;
  // Coding
  localparam logic [8:0] PN9_SEED = 9'h1FF;
  localparam logic [3:0] NRNSC_G0 = 4'hF;
  localparam logic [3:0] NRNSC_G1 = 4'hB;
  localparam logic [4:0] BITS_UNC = 5'h08;
  localparam logic [4:0] BITS_FEC = 5'h10;
  localparam logic [4:0] BITS_SFD = 5'h10;
  localparam logic [4:0] RX_PHR_LAST = 5'h0F;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_PRE  = 3'b001,
    PH_SFD  = 3'b010,
    PH_PHR  = 3'b011,
    PH_PAY  = 3'b100,
    PH_TAIL = 3'b101,
    PH_END  = 3'b110
  } sff_phase_t;
endpackage

// File: rtl/sff_whiten.sv
// Payload whitening: advances the PN9 sequence by one byte.
// Purely combinational; the caller holds the sequence state.
`timescale 1ns/1ns
module sff_whiten
  import sff_pkg::*;
(
  // Data
  input  wire logic [7:0] data_in,
  input  wire logic [8:0] pn_in,
  // Results
  output logic      [7:0] data_out,
  output logic      [8:0] pn_out
);
  logic [8:0] pn;

  always_comb begin
    pn = pn_in;
    data_out = 8'h00;
    // Bit 7 goes on air first, so it takes the first sequence bit
    for (int i = 7; i >= 0; i--) begin
      data_out[i] = data_in[i] ^ pn[0];
      pn = {pn[0] ^ pn[5], pn[8:1]};
    end
    pn_out = pn;
  end
endmodule

// File: rtl/sff_fec.sv
// Rate one half NRNSC encoder over one byte, then a 4x4
// code-symbol interleaver over the sixteen code bits.
// Combinational; the caller holds the encoder memory.
`timescale 1ns/1ns
module sff_fec
  import sff_pkg::*;
(
  // Data
  input  wire logic [7:0]  data_in,
  input  wire logic [2:0]  mem_in,
  // Results
  output logic      [15:0] code_out,
  output logic      [2:0]  mem_out
);
  logic [15:0] code;
  logic [2:0]  mem;
  logic [3:0]  win;

  always_comb begin
    mem = mem_in;
    code = 16'h0000;
    win = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      win = {data_in[i], mem};
      code[2*i+1] = ^(win & NRNSC_G0);
      code[2*i] = ^(win & NRNSC_G1);
      mem = win[3:1];
    end
    mem_out = mem;
  end

  // Transpose spreads adjacent code bits four places apart
  for (genvar g = 0; g < 16; g++) begin : g_ilv
    assign code_out[g] = code[(g % 4) * 4 + g / 4];
  end
endmodule

// File: tb/sff_framer_properties.sv
// Port assertions for the frame builder.
// Bound into every sff_framer; one clock domain, sync reset.
`timescale 1ns/1ns
module sff_framer_properties
  import sff_pkg::*;
(
  // Clock, reset and bus
  input wire logic        CLK_IN, RESET_IN, PSEL_IN, PENABLE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic        PREADY_OUT, PSLVERR_OUT,
  // Frame side
  input wire logic        TX_START_IN, TX_DONE_OUT, TX_BIT_OUT, TX_BIT_VALID_OUT,
  input wire logic        TX_BIT_READY_IN, TX_MODE_OUT, TX_FEC_OUT, RX_HDR_STB_OUT
);
  logic busy_q;

  // Mirrors the frame-in-progress state seen from the ports
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN)
      busy_q <= 1'b0;
    else if (TX_START_IN && (!busy_q || TX_DONE_OUT))
      busy_q <= 1'b1;
    else if (TX_DONE_OUT)
      busy_q <= 1'b0;
  end

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  a_start_preamble:
    assert property (TX_START_IN && (!busy_q || TX_DONE_OUT) |-> ##2 (TX_BIT_VALID_OUT && !TX_BIT_OUT))
    else $error("frame did not open with a preamble bit");
  a_bit_hold:
    assert property (TX_BIT_VALID_OUT && !TX_BIT_READY_IN |=> TX_BIT_VALID_OUT && $stable(TX_BIT_OUT))
    else $error("bit changed before it was taken");
  a_cfg_frozen:
    assert property (busy_q && $past(busy_q) && !$past(TX_DONE_OUT) |-> $stable(TX_MODE_OUT) && $stable(TX_FEC_OUT))
    else $error("mode or fec changed inside a frame");
  a_pready_setup:
    assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready in access cycle");
  a_err_unmapped:
    assert property (PSEL_IN && !PENABLE_IN && PADDR_IN > 12'h00C |=> PSLVERR_OUT)
    else $error("unmapped access without error");
  a_ok_mapped:
    assert property (PSEL_IN && !PENABLE_IN && PADDR_IN <= 12'h00C && PADDR_IN[1:0] == 2'h0 |=> !PSLVERR_OUT)
    else $error("error on mapped register");
  a_done_pulse:
    assert property (TX_DONE_OUT |-> busy_q ##1 !TX_DONE_OUT)
    else $error("done not a single pulse of a frame");
  a_stb_pulse:
    assert property (RX_HDR_STB_OUT |=> !RX_HDR_STB_OUT)
    else $error("header strobe longer than one cycle");
endmodule

bind sff_framer sff_framer_properties u_props (.CLK_IN, .RESET_IN, .PSEL_IN, .PENABLE_IN,
  .PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .TX_START_IN, .TX_DONE_OUT, .TX_BIT_OUT,
  .TX_BIT_VALID_OUT, .TX_BIT_READY_IN, .TX_MODE_OUT, .TX_FEC_OUT, .RX_HDR_STB_OUT);

// File: tb/sff_mod_model.sv
// Modulator stand-in: takes bits under a ready that may stall.
// Keeps every taken bit in order for the bench to inspect.
`timescale 1ns/1ns
module sff_mod_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic slow_in,
  input  wire logic bit_in,
  input  wire logic valid_in,
  output logic      ready_out
);
  logic bits_q [0:1023];
  int   cnt_q;
  logic ph_q;

  // Slow mode stalls every other cycle to exercise the hold
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= 0;
      ph_q <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      ph_q <= ~ph_q;
      ready_out <= !slow_in || ph_q;
      if (valid_in && ready_out) begin
        bits_q[cnt_q] <= bit_in;
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule

// File: tb/sff_framer_tb.sv
// Bench: registers, three frames, header reception.
// Assumes sff_mod_model on the bit side and the bound checker.
`timescale 1ns/1ns
module sff_framer_tb;
  import sff_pkg::*;
  logic             clk, rst, psel, pen, pwr, slow, err, start, tvalid, tready, tdone;
  logic             tbit, bvalid, bready, tmode, tfec, rbit, rvalid, rstb, rdw, pready, pslverr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic [LEN_W-1:0] tlen, rlen;
  logic [7:0]       tdata;
  int               error_cnt, cmp_count, base, stb_cnt;

  sff_framer dut (
    .CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TX_START_IN(start), .TX_LEN_IN(tlen), .TX_DATA_IN(tdata),
    .TX_VALID_IN(tvalid), .TX_READY_OUT(tready), .TX_DONE_OUT(tdone), .TX_BIT_OUT(tbit),
    .TX_BIT_VALID_OUT(bvalid), .TX_BIT_READY_IN(bready), .TX_MODE_OUT(tmode),
    .TX_FEC_OUT(tfec), .RX_BIT_IN(rbit), .RX_BIT_VALID_IN(rvalid),
    .RX_HDR_STB_OUT(rstb), .RX_LEN_OUT(rlen), .RX_DW_OUT(rdw));
  sff_mod_model mdl (.clk_in(clk), .rst_in(rst), .slow_in(slow), .bit_in(tbit),
    .valid_in(bvalid), .ready_out(bready));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (rstb === 1'b1) stb_cnt++;

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tmo(input string nm);
    error_cnt++;
    $display("CHECK FAILED %s expected response seen timeout", nm);
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic frame();
    base = mdl.cnt_q;
    start <= 1'b1;
    tlen <= 11'h001;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (tdone !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) tmo("done");
    @(posedge clk);
  endtask
  task automatic rx16(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      rbit <= v[i];
      rvalid <= 1'b1;
      @(posedge clk);
    end
  endtask
  // Sixteen taken bits from position s, first bit most significant
  function automatic logic [31:0] get16(input int s);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 16; i++) v = {v[30:0], mdl.bits_q[s + i]};
    return v;
  endfunction

  initial begin
    {psel, pen, pwr, start, slow, rbit, rvalid, paddr, pwdata, tlen} = '0;
    tvalid = 1'b1;
    tdata = 8'hA5;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b1, REG_TXCNT, 32'hFFFF);
    apb(1'b0, REG_TXCNT, 32'h0);
    chk("txcnt", 32'h0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test registers done");
    frame();
    chk("mode", 32'h0, {31'h0, tmode});
    chk("fec", 32'h0, {31'h0, tfec});
    wait_done();
    for (int u = 0; u < 4; u++) chk("preamble", 32'h5555, get16(base + 16 * u));
    chk("sfd", 32'h904E, get16(base + 64));
    chk("header", 32'h0801, get16(base + 80));
    chk("whitened", 32'h015A, get16(base + 88));
    chk("mac ready", 32'h0, {31'h0, tready});
    $display("test plain frame done");
    apb(1'b1, REG_CTRL, 32'h2);
    slow <= 1'b1;
    frame();
    apb(1'b1, REG_CTRL, 32'h1);
    chk("fec held", 32'h1, {31'h0, tfec});
    chk("mode held", 32'h0, {31'h0, tmode});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status busy", 32'h5, rd);
    wait_done();
    for (int u = 0; u < 4; u++) chk("fec preamble", 32'h5555, get16(base + 16 * u));
    chk("fec sfd", 32'h6F4E, get16(base + 64));
    chk("fec header", 32'h3331, get16(base + 80));
    $display("test coded frame done");
    slow <= 1'b0;
    frame();
    chk("mode two", 32'h1, {31'h0, tmode});
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_done();
    chk("mode two sfd", 32'h904E, get16(base + 64));
    apb(1'b0, REG_TXCNT, 32'h0);
    chk("frames", 32'h3, rd);
    $display("test mode two done");
    repeat (4) rx16(16'h5555);
    rx16(16'h7A0E);
    rx16(16'h1805);
    repeat (4) rx16(16'h5555);
    rx16(SFD0_UNC);
    rx16(16'h1805);
    rvalid <= 1'b0;
    repeat (3) @(posedge clk);
    chk("strobes", 32'h1, 32'(stb_cnt));
    chk("rx len", 32'h5, {21'h0, rlen});
    apb(1'b0, REG_RXPHR, 32'h0);
    chk("rxphr", 32'h0001_0005, rd);
    chk("rx dw", 32'h1, {31'h0, rdw});
    $display("test receive done");
    print_verdict();
  end
endmodule
